// >>> logic/module_ctrl_pkg.sv
// types for the module low-speed control block
package module_ctrl_pkg;

    // ----------------------------------------------------------------
    // serial engine states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_WRITE = 3'b011,
        ST_READ = 3'b100,
        ST_RACK = 3'b101,
        ST_SKIP = 3'b110
    } serial_state_e;

    // ----------------------------------------------------------------
    // sampled pin bundle
    // ----------------------------------------------------------------
    typedef struct packed {
        logic select_n;
        logic reset_n;
        logic low_power;
        logic scl;
        logic sda;
    } pins_s;

endpackage : module_ctrl_pkg

// >>> logic/module_ctrl_regs.svh
// constants for the module low-speed control block
`ifndef MODULE_CTRL_REGS_SVH
`define MODULE_CTRL_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define INIT_TIME_MS 2000
`define INIT_CYCLES ((`INIT_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define RESET_MIN_CYCLES 250

// ----------------------------------------------------------------
// two-wire slave address and memory map
// ----------------------------------------------------------------
`define DEV_ADDR 7'h50
`define MAP_DEPTH 128
`define ADDR_STATUS 8'h02
`define ADDR_FLAGS 8'h03
`define ADDR_CONTROL 8'h5D
`define BIT_NOT_READY 0
`define BIT_INIT_FLAG 0
`define BIT_LOW_POWER_OVR 0
`define BIT_LOW_POWER_FORCE 1
`define BIT_SEL_LOW_POWER 2
`define STATUS_RESET 8'h01

`endif

// >>> logic/module_low_speed_control.sv
// low-speed management: select, reset, low power, presence, interrupt
`timescale 1ns/1ps
`include "module_ctrl_regs.svh"

// Function
// - answer serial bus only while selected low
// - long reset pulse restores all defaults
// - completion interrupt posted with not-ready flag cleared
// - post completion interrupt after power-up unaided
// - low-power input caps power consumption
// - presence line driven low when inserted
// - open-drain interrupt low flags fault
// - fully functional within 2000 ms
// - serial lines give memory map access
module module_low_speed_control #(
    parameter int INIT_CYCLES = `INIT_CYCLES,
    parameter int RESET_MIN = `RESET_MIN_CYCLES,
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR // arbitrary slave address
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // host control pins
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_select,
    // two-wire bus, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // status pins, open drain
    output logic presence_indicator_n,
    output logic interrupt_out_n,
    output logic interrupt_oe,
    // internal status and fault input
    input wire logic fault_event,
    output logic low_power_active,
    output logic ready
);

    module_ctrl_pkg::pins_s raw; // raw pin bundle
    module_ctrl_pkg::pins_s pin; // synchronised pin bundle
    module_ctrl_pkg::serial_state_e state;
    logic scl_d, sda_d; // previous samples for edge detect
    logic scl_rise, scl_fall, start_c, stop_c;
    logic soft_rst; // reset from the pin, held long enough
    logic [15:0] rst_cnt; // low-time counter of reset pin
    logic [31:0] init_cnt; // power-on initialisation timer
    logic not_ready; // initialisation-pending flag
    logic init_flag; // latched completion flag
    logic fault_flag; // latched fault flag
    logic [7:0] ctrl; // control byte
    logic [7:0] mem [0:`MAP_DEPTH-1]; // user memory map
    logic [7:0] shreg; // serial shift register
    logic [3:0] bitn; // bit counter
    logic [7:0] ptr; // memory pointer
    logic rw; // read direction
    logic first; // next write byte is the pointer
    logic [7:0] rd_byte; // byte chosen for read

    assign raw = '{select_n: module_select_n, reset_n: module_reset_n,
                   low_power: low_power_select, scl: scl_in, sda: sda_in};

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    pin_sync #(.WIDTH(5), .INIT(5'h1B)) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in(raw),
        .sync_out(pin)
    );

    // ----------------------------------------------------------------
    // bus edge and condition detection
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= pin.scl;
            sda_d <= pin.sda;
        end
    end
    assign scl_rise = pin.scl & ~scl_d;
    assign scl_fall = ~pin.scl & scl_d;
    assign start_c = pin.scl & scl_d & sda_d & ~pin.sda & ~pin.select_n;
    assign stop_c = pin.scl & scl_d & ~sda_d & pin.sda;

    // ----------------------------------------------------------------
    // reset pin pulse length qualifier
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rst_cnt <= 16'h0000;
            soft_rst <= 1'b0;
        end else if (pin.reset_n) begin
            rst_cnt <= 16'h0000;
            soft_rst <= 1'b0;
        end else if (rst_cnt >= 16'(RESET_MIN)) begin
            soft_rst <= 1'b1;
        end else begin
            rst_cnt <= rst_cnt + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // initialisation timer and completion flag
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn || soft_rst) begin
            init_cnt <= 32'h00000000;
            not_ready <= 1'b1;
            init_flag <= 1'b0;
        end else begin
            if (not_ready) begin
                if (init_cnt >= 32'(INIT_CYCLES - 1)) begin
                    not_ready <= 1'b0;
                    init_flag <= 1'b1;
                end else begin
                    init_cnt <= init_cnt + 32'h00000001;
                end
            end else if (state == module_ctrl_pkg::ST_READ && scl_fall && bitn == 4'h0
                         && ptr == `ADDR_FLAGS) begin
                init_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // fault flag, set wins over read clear
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn || soft_rst) begin
            fault_flag <= 1'b0;
        end else if (fault_event) begin
            fault_flag <= 1'b1;
        end else if (state == module_ctrl_pkg::ST_READ && scl_fall && bitn == 4'h0
                     && ptr == `ADDR_FLAGS) begin
            fault_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // status pin outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            presence_indicator_n <= 1'b0;
            interrupt_out_n <= 1'b1;
            interrupt_oe <= 1'b0;
            low_power_active <= 1'b1;
            ready <= 1'b0;
        end else begin
            presence_indicator_n <= 1'b0;
            interrupt_out_n <= ~((init_flag & ~not_ready) | fault_flag);
            interrupt_oe <= (init_flag & ~not_ready) | fault_flag;
            ready <= ~not_ready;
            // the pin always caps power; software may only add its own request on top
            low_power_active <= pin.low_power
                                | (ctrl[`BIT_LOW_POWER_OVR] ? ctrl[`BIT_LOW_POWER_FORCE]
                                   : ctrl[`BIT_SEL_LOW_POWER]);
        end
    end

    // ----------------------------------------------------------------
    // read byte selection
    // ----------------------------------------------------------------
    always_comb begin
        case (ptr)
            `ADDR_STATUS: rd_byte = {7'h00, not_ready};
            `ADDR_FLAGS: rd_byte = {6'h00, fault_flag, init_flag};
            `ADDR_CONTROL: rd_byte = ctrl;
            default: rd_byte = (ptr < 8'(`MAP_DEPTH)) ? mem[ptr[6:0]] : 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // two-wire slave engine
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn || soft_rst) begin
            state <= module_ctrl_pkg::ST_IDLE;
            shreg <= 8'h00;
            bitn <= 4'h0;
            ptr <= 8'h00;
            rw <= 1'b0;
            first <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            ctrl <= 8'h00;
        end else if (stop_c) begin
            state <= module_ctrl_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else if (pin.select_n) begin
            // deselected mid-frame: drop the frame and let go of the data line
            state <= module_ctrl_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else if (start_c) begin
            state <= module_ctrl_pkg::ST_ADDR;
            bitn <= 4'h0;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                module_ctrl_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], pin.sda};
                        bitn <= bitn + 4'h1;
                    end else if (scl_fall && bitn == 4'h8) begin
                        rw <= shreg[0];
                        first <= ~shreg[0];
                        sda_oe <= (shreg[7:1] == DEV_ADDR);
                        state <= (shreg[7:1] == DEV_ADDR) ? module_ctrl_pkg::ST_ACK
                                 : module_ctrl_pkg::ST_SKIP;
                    end
                end
                module_ctrl_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bitn <= 4'h0;
                        if (rw) begin
                            shreg <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                            state <= module_ctrl_pkg::ST_READ;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= module_ctrl_pkg::ST_WRITE;
                        end
                    end
                end
                module_ctrl_pkg::ST_WRITE: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], pin.sda};
                        bitn <= bitn + 4'h1;
                    end else if (scl_fall && bitn == 4'h8) begin
                        sda_oe <= 1'b1;
                        state <= module_ctrl_pkg::ST_ACK;
                        first <= 1'b0;
                        if (first) begin
                            ptr <= shreg;
                        end else begin
                            ptr <= ptr + 8'h01;
                            if (shreg != 8'h00 && ptr == `ADDR_CONTROL) begin
                                ctrl <= shreg;
                            end else if (ptr == `ADDR_CONTROL) begin
                                ctrl <= 8'h00;
                            end else if (ptr < 8'(`MAP_DEPTH) && ptr > `ADDR_FLAGS) begin
                                mem[ptr[6:0]] <= shreg;
                            end
                        end
                    end
                end
                module_ctrl_pkg::ST_READ: begin
                    if (scl_fall) begin
                        if (bitn == 4'h7) begin
                            sda_oe <= 1'b0;
                            ptr <= ptr + 8'h01;
                            state <= module_ctrl_pkg::ST_RACK;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                            sda_oe <= ~shreg[6];
                            bitn <= bitn + 4'h1;
                        end
                    end
                end
                module_ctrl_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        state <= pin.sda ? module_ctrl_pkg::ST_SKIP : module_ctrl_pkg::ST_ACK;
                    end
                end
                module_ctrl_pkg::ST_SKIP: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule : module_low_speed_control

// >>> logic/pin_sync.sv
// two-flop synchroniser for a bundle of pins
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta; // first stage, read only by second

    // ----------------------------------------------------------------
    // two stages
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta <= INIT;
            sync_out <= INIT;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : pin_sync

// >>> testbench/host_master.sv
// host board model: two-wire bus master and pull-ups
`timescale 1ns/1ps

module host_master (
    // bench clock
    input wire logic core_clk,
    // wire levels seen by the host
    input wire logic sda_line,
    input wire logic interrupt_oe,
    // host drives
    output logic scl,
    output logic sda_drv,
    output logic int_line
);
    int half = 4; // cycles per clock high phase, low phase one more, 360 ns period
    // pull-up to host supply on the open-drain interrupt
    assign int_line = interrupt_oe ? 1'b0 : 1'b1;
    // clock stands high between frames, data released
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // wait bench cycles, changes land at falling edges
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask : step
    // start or repeated start
    task automatic start_bit();
        sda_drv = 1'b1;
        step(half);
        scl = 1'b1;
        step(half);
        sda_drv = 1'b0;
        step(half);
        scl = 1'b0;
        step(1);
    endtask : start_bit
    // stop, bus left idle
    task automatic stop_bit();
        sda_drv = 1'b0;
        step(half);
        scl = 1'b1;
        step(half);
        sda_drv = 1'b1;
        step(half);
    endtask : stop_bit
    // one clock pulse: drive b, sample the wire at the end of the high phase
    task automatic clock_bit(input logic b, output logic seen);
        sda_drv = b;
        step(half);
        scl = 1'b1;
        step(half);
        seen = sda_line;
        scl = 1'b0;
        step(1);
    endtask : clock_bit
    // byte out, msb first; ack is the device pulling low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
        clock_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte
    // byte in, then ack or nack from the host
    task automatic read_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
        clock_bit(nack, s);
    endtask : read_byte
endmodule : host_master

// >>> testbench/module_low_speed_control_bench.sv
// self-checking bench for the module low-speed control block
`timescale 1ns/1ps
`include "module_ctrl_regs.svh"

module module_low_speed_control_bench;
    localparam int INIT_SIM = 200; // shortened init count
    localparam int RESET_SIM = 8; // shortened minimum reset pulse
    logic core_clk, rstn, module_select_n, module_reset_n, low_power_select, fault_event;
    logic sda_out, sda_oe, presence_indicator_n, interrupt_out_n, interrupt_oe;
    logic low_power_active, ready, scl, sda_drv, int_line, sda_line, ack;
    logic [7:0] b0, b1;
    int mismatches = 0;
    int checks_done = 0;
    // open-drain data wire, pulled up
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    module_low_speed_control #(.INIT_CYCLES(INIT_SIM), .RESET_MIN(RESET_SIM))
    u_module_low_speed_control (
        .core_clk(core_clk), .rstn(rstn), .module_select_n(module_select_n),
        .module_reset_n(module_reset_n), .low_power_select(low_power_select),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .presence_indicator_n(presence_indicator_n), .interrupt_out_n(interrupt_out_n),
        .interrupt_oe(interrupt_oe), .fault_event(fault_event),
        .low_power_active(low_power_active), .ready(ready)
    );
    host_master u_host_master (
        .core_clk(core_clk), .sda_line(sda_line), .interrupt_oe(interrupt_oe),
        .scl(scl), .sda_drv(sda_drv), .int_line(int_line)
    );
    // compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask : step
    // bounded wait for the interrupt line to go low
    task automatic wait_int();
        for (int i = 0; i < INIT_SIM + 100 && int_line !== 1'b0; i++) step(1);
    endtask : wait_int
    // write one byte; ack is the and of all three acks
    task automatic write_byte(input logic [6:0] dev, input logic [7:0] ptr,
                              input logic [7:0] data, output logic ok);
        logic a1, a2, a3;
        u_host_master.start_bit();
        u_host_master.send_byte({dev, 1'b0}, a1);
        u_host_master.send_byte(ptr, a2);
        u_host_master.send_byte(data, a3);
        u_host_master.stop_bit();
        ok = a1 & a2 & a3;
    endtask : write_byte
    // read two bytes starting at ptr
    task automatic read_two(input logic [7:0] ptr, output logic [7:0] r0, output logic [7:0] r1);
        logic a;
        u_host_master.start_bit();
        u_host_master.send_byte({`DEV_ADDR, 1'b0}, a);
        u_host_master.send_byte(ptr, a);
        u_host_master.start_bit();
        u_host_master.send_byte({`DEV_ADDR, 1'b1}, a);
        u_host_master.read_byte(1'b0, r0);
        u_host_master.read_byte(1'b1, r1);
        u_host_master.stop_bit();
    endtask : read_two
    // watchdog
    initial begin
        repeat (40000) @(posedge core_clk);
        mismatches++;
        $display("watchdog expired");
        wrap_up();
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        module_select_n = 1'b0; // this module has a select line of its own
        module_reset_n = 1'b1;
        low_power_select = 1'b0;
        fault_event = 1'b0;
        step(4);
        check("presence", {7'h00, presence_indicator_n}, 8'h00);
        rstn = 1'b1;
        wait_int(); // status left unread until completion
        check("boot_int", {7'h00, int_line}, 8'h00);
        check("boot_pin", {7'h00, interrupt_out_n}, 8'h00);
        check("ready", {7'h00, ready}, 8'h01);
        read_two(`ADDR_STATUS, b0, b1);
        check("not_ready", b0 & 8'h01, 8'h00);
        check("init_flag", b1 & 8'h01, 8'h01);
        step(4);
        check("int_release", {7'h00, int_line}, 8'h01);
        write_byte(`DEV_ADDR, 8'h10, 8'hA5, ack);
        check("wr_ack", {7'h00, ack}, 8'h01);
        module_select_n = 1'b1;
        step(4);
        write_byte(`DEV_ADDR, 8'h10, 8'h5A, ack);
        check("unsel_ack", {7'h00, ack}, 8'h00);
        module_select_n = 1'b0;
        u_host_master.half = 8;
        read_two(8'h10, b0, b1);
        u_host_master.half = 4;
        check("mem_kept", b0, 8'hA5);
        write_byte(`DEV_ADDR ^ 7'h01, 8'h10, 8'h00, ack);
        check("wrong_dev", {7'h00, ack}, 8'h00);
        low_power_select = 1'b1;
        step(8);
        check("lp_on", {7'h00, low_power_active}, 8'h01);
        low_power_select = 1'b0;
        step(8);
        check("lp_off", {7'h00, low_power_active}, 8'h00);
        fault_event = 1'b1;
        step(1);
        fault_event = 1'b0;
        step(4);
        check("fault_int", {7'h00, int_line}, 8'h00);
        read_two(`ADDR_STATUS, b0, b1);
        check("fault_flag", b1 & 8'h02, 8'h02);
        step(4);
        check("fault_clear", {7'h00, int_line}, 8'h01);
        write_byte(`DEV_ADDR, `ADDR_CONTROL, 8'h04, ack);
        step(4);
        check("sw_lp", {7'h00, low_power_active}, 8'h01);
        // override with forced value low: released only while the pin is low
        write_byte(`DEV_ADDR, `ADDR_CONTROL, 8'h05, ack);
        step(4);
        check("ovr_off", {7'h00, low_power_active}, 8'h00);
        low_power_select = 1'b1;
        step(8);
        check("ovr_pin", {7'h00, low_power_active}, 8'h01);
        low_power_select = 1'b0;
        // override with forced value high
        write_byte(`DEV_ADDR, `ADDR_CONTROL, 8'h03, ack);
        step(4);
        check("ovr_on", {7'h00, low_power_active}, 8'h01);
        module_reset_n = 1'b0;
        step(2);
        module_reset_n = 1'b1;
        step(8);
        check("short_rst", {7'h00, low_power_active}, 8'h01);
        module_reset_n = 1'b0;
        step(RESET_SIM + 10);
        module_reset_n = 1'b1;
        wait_int();
        check("rst_int", {7'h00, int_line}, 8'h00);
        check("rst_default", {7'h00, low_power_active}, 8'h00);
        wrap_up();
    end
endmodule : module_low_speed_control_bench

// >>> testbench/module_low_speed_control_monitor.sv
// checker on the ports of the module low-speed control block
`timescale 1ns/1ps

module module_low_speed_control_monitor #(
    parameter int INIT_CYCLES = 200,
    parameter int RESET_MIN = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // host side inputs
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_select,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic fault_event,
    // device outputs
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic presence_indicator_n,
    input wire logic interrupt_out_n,
    input wire logic interrupt_oe,
    input wire logic low_power_active,
    input wire logic ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    int wait_cnt; // cycles spent waiting for ready
    int hold_cnt; // cycles the reset pin has been held low
    // counters for the init bound and the long reset pulse
    always_ff @(posedge core_clk) begin
        wait_cnt <= (!rstn || ready || !module_reset_n) ? 0 : wait_cnt + 1;
        hold_cnt <= (!rstn || module_reset_n) ? 0 : hold_cnt + 1;
    end
    chk_presence_low: assert property (presence_indicator_n == 1'b0)
        else $error("presence line not pulled low");
    chk_int_pin_mirror: assert property (interrupt_out_n == !interrupt_oe)
        else $error("interrupt pin and enable disagree");
    chk_sda_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    chk_unselected_quiet: assert property (module_select_n [*6] |-> !sda_oe)
        else $error("bus answered while not selected");
    chk_low_power_cap: assert property (low_power_select [*5] |-> low_power_active)
        else $error("power not capped with low power pin high");
    chk_init_bound: assert property (wait_cnt < INIT_CYCLES + 16)
        else $error("init took too long");
    chk_ready_posts_int: assert property ($rose(ready) |-> ##[0:4] interrupt_oe)
        else $error("no completion interrupt after init");
    chk_fault_posts_int: assert property (fault_event |-> ##[1:4] interrupt_oe)
        else $error("fault did not raise interrupt");
    chk_int_held_until: assert property (
        $fell(interrupt_oe) |-> !module_select_n || !module_reset_n)
        else $error("interrupt released without a read");
    chk_long_reset_clears: assert property (hold_cnt > RESET_MIN + 8 |-> !interrupt_oe)
        else $error("flags kept through long reset");
    cover property ($rose(ready));
    cover property ($rose(sda_oe));
    cover property ($fell(interrupt_oe));
endmodule : module_low_speed_control_monitor

bind module_low_speed_control module_low_speed_control_monitor #(
    .INIT_CYCLES(INIT_CYCLES), .RESET_MIN(RESET_MIN)
) u_module_low_speed_control_monitor (
    .core_clk(core_clk), .rstn(rstn), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .low_power_select(low_power_select), .scl_in(scl_in),
    .sda_in(sda_in), .fault_event(fault_event), .sda_out(sda_out), .sda_oe(sda_oe),
    .presence_indicator_n(presence_indicator_n), .interrupt_out_n(interrupt_out_n),
    .interrupt_oe(interrupt_oe), .low_power_active(low_power_active), .ready(ready)
);
